// ==== rtl/shift_port_pkg.sv ====
`default_nettype none
package shift_port_pkg;
  localparam logic [7:0] OFF_IRQ_DISABLE = 8'hc2;
  localparam logic [7:0] OFF_SHIFT_DATA  = 8'hdd;
  localparam logic [3:0] BITS_PER_XFER   = 4'h8;
  localparam int         DATA_W          = 8;
  localparam int         CNT_W           = 4;
  // Host-side APB map, one word each
  localparam logic [7:0] APB_CTRL        = 8'h00;
  localparam logic [7:0] APB_DATA        = 8'h04;
  localparam logic [7:0] APB_STATUS      = 8'h08;
  localparam logic [7:0] APB_IRQ_CLR     = 8'h0c;
  localparam logic [7:0] APB_IRQ_EN      = 8'h10;
  localparam logic [7:0] APB_SCL_CTRL    = 8'h14;
  // CTRL and SCL_CTRL fields
  localparam int CTRL_OD_BIT   = 0;
  localparam int CTRL_ACK_BIT  = 1;
  localparam int SCL_LEVEL_BIT = 0;
  localparam int SCL_DRIVE_BIT = 1;
  // STATUS fields: sticky event bits
  localparam int ST_DONE_BIT   = 0;
  localparam int ST_NUM        = 1;
  localparam int PERIOD_REG_W  = 16;
endpackage : shift_port_pkg
`default_nettype wire

// ==== rtl/shift_link_if.sv ====
`default_nettype none
interface shift_link_if;
  // Shift clock, open-drain style: low when any side drives low
  logic scl_dev_o;
  logic scl_dev_oe;
  logic scl_host_o;
  logic scl_host_oe;
  logic sin_host_o;
  logic sin_host_oe;
  logic sout_o;
  logic sout_oe;
  logic irq_n;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       scl_line;
  logic       sin_line;
  assign scl_line = !((scl_dev_oe && !scl_dev_o) || (scl_host_oe && !scl_host_o));
  assign sin_line = !((sin_host_oe && !sin_host_o) || (sout_oe && !sout_o));
  modport device (input scl_line, input sin_line, output scl_dev_o, output scl_dev_oe,
                  output sout_o, output sout_oe, output irq_n, input reg_addr, input reg_wr,
                  input reg_rd, input reg_wdata, output reg_rdata);
  modport host (input scl_line, input sin_line, output scl_host_o, output scl_host_oe,
                output sin_host_o, output sin_host_oe, input irq_n, output reg_addr,
                output reg_wr, output reg_rd, output reg_wdata, input reg_rdata);
endinterface : shift_link_if
`default_nettype wire

// ==== rtl/shift_port_device.sv ====
// Summary of operation
// - 8-bit shift register, 4-bit counter, pins
// - Data shifts most significant bit first
// - Falling shift clock advances register, counter
// - After eight pulses clocking stops
// - Interrupt on eighth edge unless rewritten
// - Reset leaves interrupt disarmed
// - Data write arms interrupt
// - Disable register write disarms interrupt
// - Interrupt signals by falling edge
// - Write or reset clears counter, enables clock
// - Slave mode: remote master drives clock
// - Master mode: software toggles clock line
// - Input pin input, output pin open-drain
// - Open-drain mode routes shift output pin
// - Interrupt marks byte done, ack ninth
// - Software may ack and stretch clock
// - Unused peripheral: avoid data writes
`default_nettype none
module shift_port_device (
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire logic     od_sel,
  shift_link_if.device  link
);
  typedef struct packed {
    logic [2:0] scl_sync;
    logic [1:0] sin_sync;
    logic [shift_port_pkg::DATA_W-1:0] shreg;
    logic [shift_port_pkg::CNT_W-1:0]  cnt;
    logic       armed;
    logic       irq_n;
    logic       sout;
    logic       sout_oe;
    logic [7:0] rdata;
  } state_t;
  state_t s_q, s_d;
  logic   fall;
  logic   run;
  ////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.scl_sync = {s_q.scl_sync[1:0], link.scl_line};
    s_d.sin_sync = {s_q.sin_sync[0], link.sin_line};
    fall = s_q.scl_sync[2] && !s_q.scl_sync[1];
    run  = s_q.cnt != shift_port_pkg::BITS_PER_XFER;
    s_d.irq_n = 1'b1;
    if (fall && run) begin
      s_d.shreg = {s_q.shreg[6:0], s_q.sin_sync[1]};
      s_d.cnt   = s_q.cnt + 4'h1;
      if (s_q.cnt == shift_port_pkg::BITS_PER_XFER - 4'h1 && s_q.armed) begin
        s_d.irq_n = 1'b0;  // One-cycle low pulse, edge-sensitive core
      end
    end
    if (link.reg_wr && link.reg_addr == shift_port_pkg::OFF_SHIFT_DATA) begin
      s_d.shreg = link.reg_wdata;  // Write beats a same-cycle shift
      s_d.cnt   = '0;
      s_d.armed = 1'b1;
      s_d.irq_n = 1'b1;            // Counter reset cancels a same-cycle eighth edge
    end
    if (link.reg_wr && link.reg_addr == shift_port_pkg::OFF_IRQ_DISABLE) begin
      s_d.armed = 1'b0;  // Value ignored
      s_d.irq_n = 1'b1;  // A same-cycle disable wins over the pulse
    end
    s_d.sout    = s_d.shreg[7];
    s_d.sout_oe = od_sel && !s_d.shreg[7];  // Open drain only pulls low
    s_d.rdata   = (link.reg_addr == shift_port_pkg::OFF_SHIFT_DATA) ? s_q.shreg : 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{scl_sync: 3'h7, sin_sync: 2'h3, shreg: 8'h00, cnt: 4'h0, armed: 1'b0,
               irq_n: 1'b1, sout: 1'b1, sout_oe: 1'b0, rdata: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end
  assign link.scl_dev_o  = 1'b1;
  assign link.scl_dev_oe = 1'b0;
  assign link.sout_o     = s_q.sout;
  assign link.sout_oe    = s_q.sout_oe;
  assign link.irq_n      = s_q.irq_n;
  assign link.reg_rdata  = s_q.rdata;
endmodule : shift_port_device
`default_nettype wire

// ==== rtl/shift_port_host.sv ====
// Local design decision: the APB interface to the registers.
`default_nettype none
module shift_port_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             od_sel,
  output logic             irq,
  shift_link_if.host       link
);
  typedef struct packed {
    logic [2:0]  irqn_sync;
    logic [1:0]  ctrl;
    logic [1:0]  scl_ctrl;
    logic        status;
    logic        irq_en;
    logic        irq;
    logic [31:0] prdata;
    logic        pready;
    logic        rd_pend;
    logic        dwr;
    logic        dwr_dis;
    logic [7:0]  wdata;
  } state_t;
  state_t s_q, s_d;
  logic   irq_fall;
  logic   acc;
  ////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.irqn_sync = {s_q.irqn_sync[1:0], link.irq_n};
    irq_fall = s_q.irqn_sync[2] && !s_q.irqn_sync[1];
    acc = psel && penable && !s_q.pready;
    s_d.pready = acc;
    s_d.dwr = 1'b0;
    s_d.dwr_dis = 1'b0;
    if (acc && pwrite) begin
      case (paddr)
        shift_port_pkg::APB_CTRL:     s_d.ctrl = pwdata[1:0];
        shift_port_pkg::APB_DATA: begin
          s_d.dwr   = 1'b1;
          s_d.wdata = pwdata[7:0];
        end
        shift_port_pkg::APB_IRQ_EN:   s_d.irq_en = pwdata[0];
        shift_port_pkg::APB_SCL_CTRL: s_d.scl_ctrl = pwdata[1:0];
        shift_port_pkg::APB_STATUS:   s_d.dwr_dis = 1'b1;  // Dummy write disarms device
        default: ;
      endcase
    end
    if (acc && pwrite && paddr == shift_port_pkg::APB_IRQ_CLR && pwdata[0]) s_d.status = 1'b0;
    if (irq_fall) s_d.status = 1'b1;  // Set wins over clear
    s_d.irq = s_d.status && s_d.irq_en;
    if (acc && !pwrite) begin
      case (paddr)
        shift_port_pkg::APB_CTRL:     s_d.prdata = {30'h0, s_q.ctrl};
        shift_port_pkg::APB_DATA:     s_d.prdata = {24'h0, link.reg_rdata};
        shift_port_pkg::APB_STATUS:   s_d.prdata = {31'h0, s_q.status};
        shift_port_pkg::APB_IRQ_EN:   s_d.prdata = {31'h0, s_q.irq_en};
        shift_port_pkg::APB_SCL_CTRL: s_d.prdata = {30'h0, s_q.scl_ctrl};
        default:                      s_d.prdata = 32'h0;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{irqn_sync: 3'h7, default: '0};
    end else begin
      s_q <= s_d;
    end
  end
  // Device read data is registered from the address, so it lags a cycle; the address rests on the data offset
  assign link.reg_addr  = s_q.dwr ? shift_port_pkg::OFF_SHIFT_DATA :
                          s_q.dwr_dis ? shift_port_pkg::OFF_IRQ_DISABLE : shift_port_pkg::OFF_SHIFT_DATA;
  assign link.reg_wr    = s_q.dwr || s_q.dwr_dis;
  assign link.reg_rd    = 1'b0;
  assign link.reg_wdata = s_q.wdata;
  assign link.scl_host_o  = s_q.scl_ctrl[shift_port_pkg::SCL_LEVEL_BIT];
  assign link.scl_host_oe = s_q.scl_ctrl[shift_port_pkg::SCL_DRIVE_BIT] &&
                            !s_q.scl_ctrl[shift_port_pkg::SCL_LEVEL_BIT];
  assign link.sin_host_o  = 1'b0;
  assign link.sin_host_oe = s_q.ctrl[shift_port_pkg::CTRL_ACK_BIT];
  assign od_sel  = s_q.ctrl[shift_port_pkg::CTRL_OD_BIT];
  assign prdata  = s_q.prdata;
  assign pready  = s_q.pready;
  assign pslverr = 1'b0;
  assign irq     = s_q.irq;
endmodule : shift_port_host
`default_nettype wire

// ==== dv/shift_link_props.sv ====
`default_nettype none
module shift_link_props (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       od_sel,
  input wire logic       scl_line,
  input wire logic       sin_line,
  input wire logic       sout_o,
  input wire logic       sout_oe,
  input wire logic       irq_n,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata
);
  logic [3:0] cnt_q;
  logic       armed_q;
  logic       scl_q;
  logic [7:0] sh_q;
  logic       fall;
  // Raw line edges: the device resyncs, so its own moves lag these by a few cycles
  assign fall = scl_q && !scl_line;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= 4'h0;
      armed_q <= 1'b0;
      scl_q   <= 1'b1;
      sh_q    <= 8'h00;
    end else begin
      scl_q <= scl_line;
      if (reg_wr && reg_addr == shift_port_pkg::OFF_SHIFT_DATA) begin
        cnt_q   <= 4'h0;
        armed_q <= 1'b1;
        sh_q    <= reg_wdata;
      end else if (fall && cnt_q < 4'h8) begin
        cnt_q <= cnt_q + 4'h1;
        sh_q  <= {sh_q[6:0], sin_line};
      end
      if (reg_wr && reg_addr == shift_port_pkg::OFF_IRQ_DISABLE) armed_q <= 1'b0;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_IRQ_PULSE: assert property ($fell(irq_n) |=> irq_n [*8]) else $error("irq pulse too long or repeated");
  AST_RESET_QUIET: assert property ($rose(presetn) |-> irq_n && !sout_oe) else $error("busy after reset");
  AST_IRQ_AFTER_EIGHT: assert property ($fell(irq_n) |-> cnt_q == 4'h8) else $error("irq not after 8 edges");
  AST_IRQ_ON_EIGHTH: assert property (fall && cnt_q == 4'h7 && armed_q |-> ##[1:8] !irq_n)
    else $error("armed transfer gave no irq");
  AST_DISARMED_QUIET: assert property (!armed_q |-> irq_n) else $error("irq while disarmed");
  AST_SOUT_MSB: assert property (od_sel && fall && cnt_q < 4'h8 |-> (sout_oe && !sout_o) == !sh_q[7])
    else $error("shift output not msb");
  AST_FROZEN: assert property (fall && cnt_q == 4'h8 |-> ##2 $stable(sout_oe) [*6]) else $error("shift after 8");
  AST_OD_GATES: assert property (!od_sel [*3] |-> !sout_oe) else $error("shift output without open drain");
  COV_IRQ: cover property ($fell(irq_n));
  COV_NINTH: cover property (fall && cnt_q == 4'h8);
  COV_DISARM: cover property (reg_wr && reg_addr == shift_port_pkg::OFF_IRQ_DISABLE);
endmodule : shift_link_props
`default_nettype wire

// ==== dv/testbench.sv ====
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, od_sel, irq, od;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          n_errors, checked;
  shift_link_if link ();
  shift_port_host shift_port_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .od_sel(od_sel), .irq(irq), .link(link));
  shift_port_device shift_port_device_i (.pclk(pclk), .presetn(presetn), .od_sel(od_sel), .link(link));
  shift_link_props shift_link_props_i (.pclk(pclk), .presetn(presetn), .od_sel(od_sel),
    .scl_line(link.scl_line), .sin_line(link.sin_line), .sout_o(link.sout_o), .sout_oe(link.sout_oe),
    .irq_n(link.irq_n), .reg_wr(link.reg_wr), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata));
  ////////////////////////////////////////
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %0t got %h want %h", $time, s, e);
    end
  endtask : check
  // Waits one edge first so a release and the next setup never share a time step
  // Only the watchdog ends a wait for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    check(r, e);
    check({31'h0, pslverr}, 32'h0);
  endtask : rd
  // Software-made shift clock: sin held low for a zero, released for a one
  task automatic xfer(input logic [7:0] v, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      wr(shift_port_pkg::APB_CTRL, {30'h0, !v[i], od});
      wr(shift_port_pkg::APB_SCL_CTRL, 32'h2);
      wr(shift_port_pkg::APB_SCL_CTRL, 32'h0);
    end
    repeat (10) @(posedge pclk);
  endtask : xfer
  task automatic report_and_stop;
    $display("n_errors=%0d checked=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    od       = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    n_errors = 0;
    checked  = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wr(shift_port_pkg::APB_IRQ_EN, 32'h1);
    rd(8'h20, 32'h0);
    wr(shift_port_pkg::APB_DATA, 32'h0);
    xfer(8'ha5, 8);
    rd(shift_port_pkg::APB_DATA, 32'ha5);
    rd(shift_port_pkg::APB_STATUS, 32'h1);
    check({31'h0, irq}, 32'h1);
    xfer(8'h00, 1);
    rd(shift_port_pkg::APB_DATA, 32'ha5);
    wr(shift_port_pkg::APB_IRQ_EN, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(shift_port_pkg::APB_IRQ_CLR, 32'h1);
    rd(shift_port_pkg::APB_STATUS, 32'h0);
    // Armed then disarmed by a dummy write: a full byte must stay silent
    wr(shift_port_pkg::APB_DATA, 32'h0);
    wr(shift_port_pkg::APB_STATUS, 32'h5a);
    xfer(8'h3c, 8);
    rd(shift_port_pkg::APB_STATUS, 32'h0);
    rd(shift_port_pkg::APB_DATA, 32'h3c);
    // A rewrite in mid-byte restarts the count
    wr(shift_port_pkg::APB_DATA, 32'h0);
    xfer(8'hf0, 4);
    wr(shift_port_pkg::APB_DATA, 32'h0);
    rd(shift_port_pkg::APB_STATUS, 32'h0);
    xfer(8'hc3, 8);
    rd(shift_port_pkg::APB_DATA, 32'hc3);
    rd(shift_port_pkg::APB_STATUS, 32'h1);
    wr(shift_port_pkg::APB_IRQ_CLR, 32'h1);
    // Loopback send: output wired onto the input returns the byte unchanged
    od = 1'b1;
    wr(shift_port_pkg::APB_DATA, 32'h5a);
    xfer(8'hff, 8);
    rd(shift_port_pkg::APB_DATA, 32'h5a);
    // Ninth pulse with the output enabled: a stray shift would move the pin
    xfer(8'h00, 1);
    rd(shift_port_pkg::APB_DATA, 32'h5a);
    rd(shift_port_pkg::APB_STATUS, 32'h1);
    od = 1'b0;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check({31'h0, irq}, 32'h0);
    xfer(8'hff, 8);
    rd(shift_port_pkg::APB_STATUS, 32'h0);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
